//--- rtl/aab_regs.vh
`ifndef AAB_REGS_VH
`define AAB_REGS_VH

`define AAB_CLK_MHZ 20
`define AAB_ACK_WAIT_US 130
`define AAB_FIFO_DEPTH 3
`define AAB_NUM_PIPES 6

`define AAB_REG_CTRL 8'h00
`define AAB_REG_STATUS 8'h04
`define AAB_REG_TX_DATA 8'h08
`define AAB_REG_RX_DATA 8'h0c
`define AAB_REG_TX_CMD 8'h10
`define AAB_REG_P0_ADDR_LO 8'h14
`define AAB_REG_P0_ADDR_HI 8'h18
`define AAB_REG_COMMON_HI 8'h1c
`define AAB_REG_PIPE_LOW 8'h20
`define AAB_REG_PIPE5_LOW 8'h24
`define AAB_REG_TX_ADDR_LO 8'h28
`define AAB_REG_TX_ADDR_HI 8'h2c

`define AAB_CTRL_ROLE_BIT 0
`define AAB_CTRL_RETRY_LSB 4
`define AAB_CTRL_RETRY_MSB 7
`define AAB_CTRL_RESET 32'h0000_0030

`define AAB_ST_RX_BIT 0
`define AAB_ST_SENT_BIT 1
`define AAB_ST_RETRY_BIT 2
`define AAB_ST_PIPE_LSB 4
`define AAB_ST_PIPE_MSB 6
`define AAB_ST_TX_FULL_BIT 8
`define AAB_ST_TX_EMPTY_BIT 9
`define AAB_ST_RX_FULL_BIT 10
`define AAB_ST_RX_EMPTY_BIT 11

`define AAB_PREAMBLE 8'haa
`define AAB_CRC_POLY 8'h07
`define AAB_CRC_INIT 8'hff
`define AAB_DATA_LAST_IDX 4'ha
`define AAB_ACK_LAST_IDX 4'h6

`endif

//--- rtl/aab_pkt_fifo.v
`default_nettype none

module aab_pkt_fifo #(
    parameter WIDTH = 35
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_push,
    input wire [WIDTH-1:0] i_data,
    input wire i_pop,
    output wire [WIDTH-1:0] o_data,
    output wire o_full,
    output wire o_empty
);
`include "aab_regs.vh"

    reg [WIDTH-1:0] mem_ff [0:`AAB_FIFO_DEPTH-1];
    reg [1:0] wr_ptr_ff;
    reg [1:0] rd_ptr_ff;
    reg [1:0] count_ff;
    wire do_push;
    wire do_pop;

    assign o_full = (count_ff == 2'd3);
    assign o_empty = (count_ff == 2'd0);
    assign o_data = mem_ff[rd_ptr_ff];
    // A push into a full queue and a pop from an empty one are dropped here.
    assign do_push = i_push && !o_full;
    assign do_pop = i_pop && !o_empty;

    function [1:0] ptr_inc;
        input [1:0] p;
        begin
            ptr_inc = (p == 2'd2) ? 2'd0 : p + 2'd1;
        end
    endfunction

    always @(posedge i_clk)
    begin
        if (i_ce && do_push)
        begin
            mem_ff[wr_ptr_ff] <= i_data;
        end
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_ptr_ff <= 2'd0;
            rd_ptr_ff <= 2'd0;
            count_ff <= 2'd0;
        end
        else if (i_ce)
        begin
            if (do_push)
            begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (do_pop)
            begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            if (do_push && !do_pop)
            begin
                count_ff <= count_ff + 2'd1;
            end
            else if (do_pop && !do_push)
            begin
                count_ff <= count_ff - 2'd1;
            end
        end
    end

endmodule // aab_pkt_fifo

`default_nettype wire

//--- rtl/aab_link_engine.v
// Operation
// - Three-deep shared RX queue, three-deep TX queue.
// - Transmitter adds preamble and CRC itself.
// - Interrupt on completed transmission.
// - Interrupt on valid packet stored.
// - Receiver role accepts six pipes, reports pipe.
// - Distinct address per pipe, one channel.
// - Pipe zero matches full 40-bit address.
// - Pipes 1-5: own low byte, shared upper.
// - All pipes auto-acknowledge.
// - Acknowledge with receiving pipe's address.
// - Transmitter role takes acknowledge on pipe zero.
// - Send queued packet when host requests.
// - Receiver on after send, await acknowledge.
// - Resend until acknowledged or retries exceeded.
// - Retries exceeded sets flag and interrupt.
// - Acknowledge pops TX, sets sent-ok flag.
// - Host reaches both queues at any time.
`default_nettype none

module aab_link_engine (
    input wire I_REF_CLK,
    input wire I_SYS_RST,
    input wire I_CE,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output wire O_PREADY,
    output reg O_PSLVERR,
    output wire O_IRQ,
    output reg O_AIR_TX_VALID,
    output reg [7:0] O_AIR_TX_BYTE,
    output reg O_AIR_TX_LAST,
    output wire O_AIR_RX_ON,
    input wire I_AIR_RX_VALID,
    input wire I_AIR_RX_ACK,
    input wire I_AIR_RX_CRC_OK,
    input wire [39:0] I_AIR_RX_ADDR,
    input wire [31:0] I_AIR_RX_DATA
);
`include "aab_regs.vh"

    localparam [15:0] ACK_WAIT_CYC = `AAB_ACK_WAIT_US * `AAB_CLK_MHZ;
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_SEND = 2'd1;
    localparam [1:0] ST_WAIT_ACK = 2'd2;
    localparam [1:0] ST_SEND_ACK = 2'd3;

    reg [31:0] ctrl_ff;
    reg [31:0] p0_lo_ff;
    reg [7:0] p0_hi_ff;
    reg [31:0] common_hi_ff;
    reg [31:0] pipe_low_ff;
    reg [7:0] pipe5_low_ff;
    reg [31:0] tx_addr_lo_ff;
    reg [7:0] tx_addr_hi_ff;
    reg rx_flag_ff;
    reg sent_ok_flag_ff;
    reg retry_limit_flag_ff;
    reg tx_req_ff;
    reg [1:0] state_ff;
    reg [3:0] idx_ff;
    reg [7:0] crc_ff;
    reg [39:0] frame_addr_ff;
    reg [15:0] wait_ff;
    reg [3:0] retry_cnt_ff;
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;
    reg [2:0] match_pipe;
    reg match_hit;
    integer i;

    wire setup_phase = I_PSEL && !I_PENABLE;
    wire access = I_PSEL && I_PENABLE;
    wire wr_en = access && I_PWRITE;
    wire rd_en = access && !I_PWRITE;
    wire primary_receiver_role = ctrl_ff[`AAB_CTRL_ROLE_BIT];
    wire [3:0] retry_setup_count_field = ctrl_ff[`AAB_CTRL_RETRY_MSB:`AAB_CTRL_RETRY_LSB];
    wire [31:0] tx_head;
    wire [34:0] rx_head;
    wire tx_full;
    wire tx_empty;
    wire rx_full;
    wire rx_empty;
    wire rx_good = I_AIR_RX_VALID && I_AIR_RX_CRC_OK;
    wire ack_frame = (state_ff == ST_SEND_ACK);
    wire [3:0] last_idx = ack_frame ? `AAB_ACK_LAST_IDX : `AAB_DATA_LAST_IDX;
    wire tx_pop;
    wire rx_push;
    wire rx_pop = rd_en && (I_PADDR == `AAB_REG_RX_DATA);
    wire tx_push = wr_en && (I_PADDR == `AAB_REG_TX_DATA);
    wire clr_wr = wr_en && (I_PADDR == `AAB_REG_STATUS);

    assign O_PREADY = 1'b1;
    assign O_IRQ = rx_flag_ff || sent_ok_flag_ff || retry_limit_flag_ff;
    // Receiver on once the last byte is out.
    // The last byte still stands while the state has moved on, so the link stays half duplex.
    assign O_AIR_RX_ON = !O_AIR_TX_VALID && ((state_ff == ST_WAIT_ACK)
        || (primary_receiver_role && state_ff == ST_IDLE));

    function [7:0] crc_step;
        input [7:0] crc;
        input [7:0] data;
        reg [7:0] c;
        integer b;
        begin
            c = crc ^ data;
            for (b = 0; b < 8; b = b + 1)
            begin
                c = c[7] ? ((c << 1) ^ `AAB_CRC_POLY) : (c << 1);
            end
            crc_step = c;
        end
    endfunction

    function [39:0] pipe_addr;
        input [2:0] p;
        begin
            case (p)
                3'd0: pipe_addr = {p0_hi_ff, p0_lo_ff};
                3'd1: pipe_addr = {common_hi_ff, pipe_low_ff[7:0]};
                3'd2: pipe_addr = {common_hi_ff, pipe_low_ff[15:8]};
                3'd3: pipe_addr = {common_hi_ff, pipe_low_ff[23:16]};
                3'd4: pipe_addr = {common_hi_ff, pipe_low_ff[31:24]};
                3'd5: pipe_addr = {common_hi_ff, pipe5_low_ff};
                default: pipe_addr = 40'h00_0000_0000;
            endcase
        end
    endfunction

    always @*
    begin
        match_hit = 1'b0;
        match_pipe = 3'd0;
        for (i = `AAB_NUM_PIPES - 1; i >= 0; i = i - 1)
        begin
            if (pipe_addr(i[2:0]) == I_AIR_RX_ADDR)
            begin
                match_hit = 1'b1;
                match_pipe = i[2:0];
            end
        end
    end

    assign rx_push = primary_receiver_role && state_ff == ST_IDLE && rx_good
        && !I_AIR_RX_ACK && match_hit && !rx_full;
    assign tx_pop = state_ff == ST_WAIT_ACK && rx_good && I_AIR_RX_ACK
        && I_AIR_RX_ADDR == pipe_addr(3'd0);

    aab_pkt_fifo #(
        .WIDTH(32)
    ) u_tx_fifo (
        .i_clk(I_REF_CLK),
        .i_rst(I_SYS_RST),
        .i_ce(I_CE),
        .i_push(tx_push),
        .i_data(I_PWDATA),
        .i_pop(tx_pop),
        .o_data(tx_head),
        .o_full(tx_full),
        .o_empty(tx_empty)
    );

    aab_pkt_fifo #(
        .WIDTH(35)
    ) u_rx_fifo (
        .i_clk(I_REF_CLK),
        .i_rst(I_SYS_RST),
        .i_ce(I_CE),
        .i_push(rx_push),
        .i_data({match_pipe, I_AIR_RX_DATA}),
        .i_pop(rx_pop),
        .o_data(rx_head),
        .o_full(rx_full),
        .o_empty(rx_empty)
    );

    // Queue access never gated by state.
    always @*
    begin
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        case (I_PADDR)
            `AAB_REG_CTRL: nxt_prdata = ctrl_ff;
            `AAB_REG_STATUS:
            begin
                nxt_prdata[`AAB_ST_RX_BIT] = rx_flag_ff;
                nxt_prdata[`AAB_ST_SENT_BIT] = sent_ok_flag_ff;
                nxt_prdata[`AAB_ST_RETRY_BIT] = retry_limit_flag_ff;
                nxt_prdata[`AAB_ST_PIPE_MSB:`AAB_ST_PIPE_LSB] = rx_empty ? 3'd7 : rx_head[34:32];
                nxt_prdata[`AAB_ST_TX_FULL_BIT] = tx_full;
                nxt_prdata[`AAB_ST_TX_EMPTY_BIT] = tx_empty;
                nxt_prdata[`AAB_ST_RX_FULL_BIT] = rx_full;
                nxt_prdata[`AAB_ST_RX_EMPTY_BIT] = rx_empty;
            end
            `AAB_REG_TX_DATA: nxt_prdata = 32'h0000_0000;
            `AAB_REG_RX_DATA: nxt_prdata = rx_empty ? 32'h0000_0000 : rx_head[31:0];
            `AAB_REG_TX_CMD: nxt_prdata = {31'h0000_0000, tx_req_ff};
            `AAB_REG_P0_ADDR_LO: nxt_prdata = p0_lo_ff;
            `AAB_REG_P0_ADDR_HI: nxt_prdata = {24'h00_0000, p0_hi_ff};
            `AAB_REG_COMMON_HI: nxt_prdata = common_hi_ff;
            `AAB_REG_PIPE_LOW: nxt_prdata = pipe_low_ff;
            `AAB_REG_PIPE5_LOW: nxt_prdata = {24'h00_0000, pipe5_low_ff};
            `AAB_REG_TX_ADDR_LO: nxt_prdata = tx_addr_lo_ff;
            `AAB_REG_TX_ADDR_HI: nxt_prdata = {24'h00_0000, tx_addr_hi_ff};
            default: nxt_pslverr = 1'b1;
        endcase
    end

    // Read data is captured in the setup cycle so it comes from flops at the access edge.
    always @(posedge I_REF_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end
        else if (I_CE && setup_phase)
        begin
            O_PRDATA <= nxt_prdata;
            O_PSLVERR <= nxt_pslverr;
        end
    end

    always @(posedge I_REF_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            ctrl_ff <= `AAB_CTRL_RESET;
            p0_lo_ff <= 32'h0000_0000;
            p0_hi_ff <= 8'h00;
            common_hi_ff <= 32'h0000_0000;
            pipe_low_ff <= 32'h0000_0000;
            pipe5_low_ff <= 8'h00;
            tx_addr_lo_ff <= 32'h0000_0000;
            tx_addr_hi_ff <= 8'h00;
        end
        else if (I_CE && wr_en)
        begin
            case (I_PADDR)
                `AAB_REG_CTRL: ctrl_ff <= I_PWDATA;
                `AAB_REG_P0_ADDR_LO: p0_lo_ff <= I_PWDATA;
                `AAB_REG_P0_ADDR_HI: p0_hi_ff <= I_PWDATA[7:0];
                `AAB_REG_COMMON_HI: common_hi_ff <= I_PWDATA;
                `AAB_REG_PIPE_LOW: pipe_low_ff <= I_PWDATA;
                `AAB_REG_PIPE5_LOW: pipe5_low_ff <= I_PWDATA[7:0];
                `AAB_REG_TX_ADDR_LO: tx_addr_lo_ff <= I_PWDATA;
                `AAB_REG_TX_ADDR_HI: tx_addr_hi_ff <= I_PWDATA[7:0];
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // Sticky flags, write one to clear, set beats clear.
    always @(posedge I_REF_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            rx_flag_ff <= 1'b0;
            sent_ok_flag_ff <= 1'b0;
            retry_limit_flag_ff <= 1'b0;
            tx_req_ff <= 1'b0;
        end
        else if (I_CE)
        begin
            if (rx_push)
                rx_flag_ff <= 1'b1;
            else if (clr_wr && I_PWDATA[`AAB_ST_RX_BIT])
                rx_flag_ff <= 1'b0;
            if (tx_pop)
                sent_ok_flag_ff <= 1'b1;
            else if (clr_wr && I_PWDATA[`AAB_ST_SENT_BIT])
                sent_ok_flag_ff <= 1'b0;
            if (state_ff == ST_WAIT_ACK && !tx_pop && wait_ff == 16'd0
                && retry_cnt_ff >= retry_setup_count_field)
                retry_limit_flag_ff <= 1'b1;
            else if (clr_wr && I_PWDATA[`AAB_ST_RETRY_BIT])
                retry_limit_flag_ff <= 1'b0;
            if (wr_en && I_PADDR == `AAB_REG_TX_CMD && I_PWDATA[0])
                tx_req_ff <= 1'b1;
            else if (state_ff == ST_IDLE && !primary_receiver_role && !tx_empty
                && !retry_limit_flag_ff)
                tx_req_ff <= 1'b0;
        end
    end

    always @(posedge I_REF_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= 4'h0;
            crc_ff <= `AAB_CRC_INIT;
            frame_addr_ff <= 40'h00_0000_0000;
            wait_ff <= 16'd0;
            retry_cnt_ff <= 4'h0;
            O_AIR_TX_VALID <= 1'b0;
            O_AIR_TX_BYTE <= 8'h00;
            O_AIR_TX_LAST <= 1'b0;
        end
        else if (I_CE)
        begin
            O_AIR_TX_VALID <= 1'b0;
            O_AIR_TX_LAST <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    idx_ff <= 4'h0;
                    crc_ff <= `AAB_CRC_INIT;
                    // No sending while retry limit stands.
                    if (!primary_receiver_role && tx_req_ff && !tx_empty
                        && !retry_limit_flag_ff)
                    begin
                        frame_addr_ff <= {tx_addr_hi_ff, tx_addr_lo_ff};
                        retry_cnt_ff <= 4'h0;
                        state_ff <= ST_SEND;
                    end
                    // Reply with the receiving pipe's address.
                    else if (rx_push)
                    begin
                        frame_addr_ff <= pipe_addr(match_pipe);
                        state_ff <= ST_SEND_ACK;
                    end
                end
                ST_SEND, ST_SEND_ACK:
                begin
                    O_AIR_TX_VALID <= 1'b1;
                    O_AIR_TX_LAST <= (idx_ff == last_idx);
                    if (idx_ff == 4'h0)
                        O_AIR_TX_BYTE <= `AAB_PREAMBLE;
                    else if (idx_ff == last_idx)
                        O_AIR_TX_BYTE <= crc_ff;
                    else
                    begin
                        O_AIR_TX_BYTE <= (idx_ff < 4'h6)
                            ? frame_addr_ff[8 * (5 - idx_ff) +: 8]
                            : tx_head[8 * (9 - idx_ff) +: 8];
                        crc_ff <= crc_step(crc_ff, (idx_ff < 4'h6)
                            ? frame_addr_ff[8 * (5 - idx_ff) +: 8]
                            : tx_head[8 * (9 - idx_ff) +: 8]);
                    end
                    idx_ff <= idx_ff + 4'h1;
                    if (idx_ff == last_idx)
                    begin
                        wait_ff <= ACK_WAIT_CYC;
                        state_ff <= ack_frame ? ST_IDLE : ST_WAIT_ACK;
                    end
                end
                ST_WAIT_ACK:
                begin
                    idx_ff <= 4'h0;
                    crc_ff <= `AAB_CRC_INIT;
                    if (tx_pop)
                        state_ff <= ST_IDLE;
                    else if (wait_ff != 16'd0)
                        wait_ff <= wait_ff - 16'd1;
                    else if (retry_cnt_ff >= retry_setup_count_field)
                        state_ff <= ST_IDLE;
                    else
                    begin
                        retry_cnt_ff <= retry_cnt_ff + 4'h1;
                        state_ff <= ST_SEND;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

endmodule // aab_link_engine

`default_nettype wire

//--- dv/aab_link_engine_assertions.sv
`default_nettype none
module aab_link_engine_assertions (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [7:0] I_PADDR,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_IRQ,
    input wire logic O_AIR_TX_VALID,
    input wire logic [7:0] O_AIR_TX_BYTE,
    input wire logic O_AIR_TX_LAST,
    input wire logic O_AIR_RX_ON
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SYS_RST || !I_CE);
    a_queue_access_ok: assert property (I_PSEL && I_PENABLE && (I_PADDR == 8'h08
        || I_PADDR == 8'h0c) |-> O_PREADY && !O_PSLVERR)
        else $error("queue access refused");
    a_unmapped_error: assert property (I_PSEL && I_PENABLE && I_PADDR == 8'h30 |-> O_PSLVERR)
        else $error("unmapped access without error");
    a_preamble_first: assert property ($rose(O_AIR_TX_VALID) |-> O_AIR_TX_BYTE == 8'haa)
        else $error("frame does not open with preamble");
    a_frame_body: assert property ($rose(O_AIR_TX_VALID) |->
        (O_AIR_TX_VALID && !O_AIR_TX_LAST)[*6] ##1 O_AIR_TX_VALID)
        else $error("frame shorter than seven bytes");
    a_last_closes: assert property (O_AIR_TX_LAST |-> O_AIR_TX_VALID ##1 !O_AIR_TX_VALID)
        else $error("last byte does not close frame");
    a_listen_after: assert property ($fell(O_AIR_TX_VALID) |-> ##[0:1] O_AIR_RX_ON)
        else $error("receiver not on after frame");
    a_deaf_sending: assert property (O_AIR_TX_VALID |-> !O_AIR_RX_ON)
        else $error("receiver on while sending");
    a_irq_holds: assert property (O_IRQ && !(I_PSEL && I_PENABLE) |=> O_IRQ)
        else $error("interrupt dropped without host access");
endmodule // aab_link_engine_assertions
bind aab_link_engine aab_link_engine_assertions u_chk (
    .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_IRQ(O_IRQ), .O_AIR_TX_VALID(O_AIR_TX_VALID), .O_AIR_TX_BYTE(O_AIR_TX_BYTE),
    .O_AIR_TX_LAST(O_AIR_TX_LAST), .O_AIR_RX_ON(O_AIR_RX_ON)
);
`default_nettype wire

//--- dv/aab_peer_radio.sv
`default_nettype none
module aab_peer_radio (
    input wire logic clk,
    input wire logic ack_en,
    input wire logic [7:0] ack_lag,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    output logic rx_valid,
    output logic rx_ack,
    output logic rx_crc_ok,
    output logic [39:0] rx_addr,
    output logic [31:0] rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] frm [0:10];
    int nb = 0;
    int len = 0;
    int frames = 0;
    initial
    begin
        rx_valid = 1'b0;
        rx_ack = 1'b0;
        rx_crc_ok = 1'b0;
        rx_addr = 40'h0;
        rx_data = 32'h0;
    end
    // Lines carry the inverse after a frame so a stale copy can never look valid.
    task automatic send(input logic ack, input logic [39:0] a, input logic [31:0] d);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_ack <= ack;
        rx_crc_ok <= 1'b1;
        rx_addr <= a;
        rx_data <= d;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_ack <= ~ack;
        rx_crc_ok <= 1'b0;
        rx_addr <= ~a;
        rx_data <= ~d;
    endtask
    task automatic ack_later(input logic [39:0] a);
        repeat (ack_lag) @(posedge clk);
        send(1'b1, a, 32'h0);
    endtask
    always @(posedge clk)
    begin
        if (tx_valid)
        begin
            frm[nb] = tx_byte;
            nb++;
            if (tx_last)
            begin
                len = nb;
                nb = 0;
                frames++;
                if (len == 11 && ack_en)
                    fork
                        ack_later({frm[1], frm[2], frm[3], frm[4], frm[5]});
                    join_none
            end
        end
    end
endmodule // aab_peer_radio
`default_nettype wire

//--- dv/aab_link_engine_tb.sv
`default_nettype none
`include "aab_regs.vh"
module aab_link_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ack_en = 1'b0;
    logic [7:0] ack_lag = 8'hc8;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int samples_checked = 0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, txv, txl, rxon, rxv, rxa, rxc;
    wire [7:0] txb;
    wire [39:0] rxad;
    wire [31:0] rxd;
    logic [39:0] adr [0:4] = '{40'h0102030405, 40'h1122334422, 40'h1122334455,
        40'he5a1b2c3d4, 40'h1122334411};
    logic [31:0] pe [0:2] = '{32'h20, 32'h50, 32'h0};
    always #25 clk = ~clk;
    aab_link_engine dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq),
        .O_AIR_TX_VALID(txv), .O_AIR_TX_BYTE(txb), .O_AIR_TX_LAST(txl), .O_AIR_RX_ON(rxon),
        .I_AIR_RX_VALID(rxv), .I_AIR_RX_ACK(rxa), .I_AIR_RX_CRC_OK(rxc),
        .I_AIR_RX_ADDR(rxad), .I_AIR_RX_DATA(rxd));
    aab_peer_radio peer (.clk(clk), .ack_en(ack_en), .ack_lag(ack_lag), .tx_valid(txv),
        .tx_byte(txb), .tx_last(txl), .rx_valid(rxv), .rx_ack(rxa), .rx_crc_ok(rxc),
        .rx_addr(rxad), .rx_data(rxd));
    task automatic wrap_up();
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wait_st(input int b);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `AAB_REG_STATUS, 32'h0);
            n++;
        end
        while (rd[b] !== 1'b1 && n < 4000);
    endtask
    task automatic irq_is(input logic [31:0] exp);
        @(negedge clk);
        chk({31'h0, irq}, exp);
    endtask
    function automatic logic [7:0] crc8(input logic [71:0] v, input int n);
        logic [7:0] c;
        logic fb;
        c = 8'hff;
        for (int i = 8 * n - 1; i >= 0; i--)
        begin
            fb = c[7] ^ v[i];
            c = {c[6:0], 1'b0} ^ {5'h0, fb, fb, fb};
        end
        return c;
    endfunction
    task automatic chk_frame(input logic [71:0] v, input int n);
        chk(peer.len, n + 2);
        chk({24'h0, peer.frm[0]}, 32'haa);
        for (int i = 0; i < n; i++)
            chk({24'h0, peer.frm[i + 1]}, {24'h0, v[8 * (n - i) - 1 -: 8]});
        chk({24'h0, peer.frm[n + 1]}, {24'h0, crc8(v, n)});
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        wrap_up();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `AAB_REG_CTRL, 32'h0);
        chk(rd, `AAB_CTRL_RESET);
        apb(1'b0, `AAB_REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0a70);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, `AAB_REG_TX_ADDR_LO, 32'ha1b2c3d4);
        apb(1'b1, `AAB_REG_TX_ADDR_HI, 32'h0000_00e5);
        // Pipe zero listens on the TX address.
        apb(1'b1, `AAB_REG_P0_ADDR_LO, 32'ha1b2c3d4);
        apb(1'b1, `AAB_REG_P0_ADDR_HI, 32'h0000_00e5);
        apb(1'b1, `AAB_REG_TX_DATA, 32'hcafe0123);
        ack_en <= 1'b1;
        apb(1'b1, `AAB_REG_TX_CMD, 32'h1);
        // Push while the frame is on air.
        apb(1'b1, `AAB_REG_TX_DATA, 32'h5a5a0f0f);
        wait_st(`AAB_ST_SENT_BIT);
        chk_frame({40'he5a1b2c3d4, 32'hcafe0123}, 9);
        chk(peer.frames, 32'h1);
        chk(rd & 32'h0000_0f02, 32'h0000_0802);
        irq_is(32'h1);
        apb(1'b1, `AAB_REG_STATUS, 32'h2);
        irq_is(32'h0);
        ack_en <= 1'b0;
        apb(1'b1, `AAB_REG_CTRL, 32'h0000_0010);
        apb(1'b1, `AAB_REG_TX_CMD, 32'h1);
        repeat (100) @(posedge clk);
        @(negedge clk);
        chk({31'h0, rxon}, 32'h1);
        wait_st(`AAB_ST_RETRY_BIT);
        chk(peer.frames, 32'h3);
        chk_frame({40'he5a1b2c3d4, 32'h5a5a0f0f}, 9);
        chk(rd & 32'h0000_0200, 32'h0);
        repeat (3000) @(posedge clk);
        chk(peer.frames, 32'h3);
        irq_is(32'h1);
        // A clear written while the clock enable is low must not land.
        @(posedge clk);
        ce <= 1'b0;
        apb(1'b1, `AAB_REG_STATUS, 32'h4);
        ce <= 1'b1;
        irq_is(32'h1);
        apb(1'b1, `AAB_REG_STATUS, 32'h4);
        irq_is(32'h0);
        apb(1'b1, `AAB_REG_CTRL, 32'h0000_0001);
        apb(1'b1, `AAB_REG_COMMON_HI, 32'h11223344);
        apb(1'b1, `AAB_REG_PIPE_LOW, 32'h44332211);
        apb(1'b1, `AAB_REG_PIPE5_LOW, 32'h0000_0055);
        for (int k = 0; k < 5; k++)
        begin
            int f;
            f = peer.frames;
            peer.send(1'b0, adr[k], k);
            repeat (30) @(posedge clk);
            chk(peer.frames, f + (k >= 1 && k <= 3));
            if (k >= 1 && k <= 3)
                chk_frame({32'h0, adr[k]}, 5);
        end
        irq_is(32'h1);
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b0, `AAB_REG_STATUS, 32'h0);
            chk(rd & 32'h0000_0470, pe[k] | (k == 0 ? 32'h400 : 32'h0));
            apb(1'b0, `AAB_REG_RX_DATA, 32'h0);
            chk(rd, k + 1);
        end
        apb(1'b0, `AAB_REG_STATUS, 32'h0);
        chk(rd & 32'h0000_0c70, 32'h0000_0870);
        wrap_up();
    end
endmodule // aab_link_engine_tb
`default_nettype wire
